/* File: logic/sce_pkg.sv */
// constants and types for the command decoder and function enable block
`default_nettype none
package sce_pkg;
  // command byte layout
  localparam int          SCE_CMD_BIT     = 7;
  localparam int          SCE_TYPE_HI     = 6;
  localparam int          SCE_TYPE_LO     = 5;
  localparam int          SCE_FIELD_HI    = 4;
  localparam int          SCE_FIELD_LO    = 0;
  localparam logic [1:0]  SCE_TYPE_REPEAT = 2'h0;
  localparam logic [1:0]  SCE_TYPE_AUTO   = 2'h1;
  localparam logic [1:0]  SCE_TYPE_RSVD   = 2'h2;
  localparam logic [1:0]  SCE_TYPE_SPECIAL = 2'h3;
  localparam logic [4:0]  SCE_SF_IRQ_SET  = 5'h04;
  localparam logic [4:0]  SCE_SF_IRQ_CLR  = 5'h05;
  // register addresses
  localparam logic [4:0]  SCE_ADDR_ENABLE = 5'h00;
  localparam logic [4:0]  SCE_ADDR_STATUS = 5'h13;
  localparam int          SCE_STATUS_PINT_BIT = 5;
  // reset values and enable write mask
  localparam logic [4:0]  SCE_PTR_RST     = 5'h00;
  localparam logic [7:0]  SCE_ENABLE_RST  = 8'h00;
  localparam logic [7:0]  SCE_ENABLE_WMASK = 8'h6d;

  // transfer mode held by the command pointer
  typedef enum logic {
    SCE_MODE_REPEAT,
    SCE_MODE_AUTOINC
  } sce_mode_t;

  // function enable register fields
  typedef struct packed {
    logic rsvd7;
    logic sleep_after_irq;
    logic prox_irq_route_enable;
    logic rsvd4;
    logic wait_enable;
    logic prox_measure_enable;
    logic rsvd1;
    logic oscillator_power_on;
  } sce_enable_t;

  // link side state
  typedef struct packed {
    logic [4:0]  ptr;
    sce_mode_t   mode;
    sce_enable_t en;
    logic        set_tgl;
    logic        clr_tgl;
    logic        pint_s1;
    logic        pint_s2;
    logic [7:0]  rd_data;
    logic        wr_stb;
    logic [4:0]  wr_addr;
    logic [7:0]  wr_data;
  } sce_link_st_t;

  // core side state
  typedef struct packed {
    sce_enable_t en_s1;
    sce_enable_t en_s2;
    logic [2:0]  set_sync;
    logic [2:0]  clr_sync;
    logic        pend;
    logic        sleep;
    logic        int_n;
    logic        osc;
    logic        prox;
    logic        wait_en;
  } sce_core_st_t;
endpackage
`default_nettype wire

/* File: logic/sce_cmd_enable.sv */
// command byte decoder, function enable register and interrupt pending logic
`default_nettype none
module sce_cmd_enable
  import sce_pkg::*;
(
  input  wire logic       CLK,             // core clock, 200 MHz
  input  wire logic       RESETN,          // async reset, active low
  input  wire logic       LINK_CLK,        // serial byte engine clock
  input  wire logic       LINK_WR_STB,     // byte written by host
  input  wire logic       LINK_WR_FIRST,   // byte is first after address
  input  wire logic [7:0] LINK_WR_DATA,    // written byte
  input  wire logic       LINK_RD_STB,     // host wants the next byte
  output var  logic [7:0] LINK_RD_DATA,    // byte read back
  output var  logic       REG_WR_STB,      // data write to other registers
  output var  logic [4:0] REG_WR_ADDR,     // its address
  output var  logic [7:0] REG_WR_DATA,     // its data
  input  wire logic       PROX_IRQ_EVENT,  // measurement raised interrupt
  input  wire logic       PROX_CYCLE_END,  // proximity cycle finished
  output var  logic       INT_N,           // interrupt pin, active low
  output var  logic       OSC_ON,          // oscillator running
  output var  logic       PROX_MEAS_EN,    // proximity engine enabled
  output var  logic       WAIT_TIMER_EN,   // wait timer enabled
  output var  logic       SLEEP_STATE      // powered down after interrupt
);

  sce_link_st_t lq;
  sce_link_st_t ld;
  sce_core_st_t cq;
  sce_core_st_t cd;

  logic       is_cmd;
  logic [1:0] cmd_type;
  logic [4:0] cmd_field;
  logic       set_ev;
  logic       clr_ev;

  // command byte fields
  assign is_cmd    = LINK_WR_STB && LINK_WR_FIRST && LINK_WR_DATA[SCE_CMD_BIT];
  assign cmd_type  = LINK_WR_DATA[SCE_TYPE_HI:SCE_TYPE_LO];
  assign cmd_field = LINK_WR_DATA[SCE_FIELD_HI:SCE_FIELD_LO];

  // link side next state
  always_comb begin
    ld        = lq;
    ld.wr_stb = 1'b0;
    ld.pint_s1 = cq.pend;
    ld.pint_s2 = lq.pint_s1;
    if (is_cmd) begin
      case (cmd_type)
        SCE_TYPE_REPEAT: begin
          ld.ptr  = cmd_field;
          ld.mode = SCE_MODE_REPEAT;
        end
        SCE_TYPE_AUTO: begin
          ld.ptr  = cmd_field;
          ld.mode = SCE_MODE_AUTOINC;
        end
        SCE_TYPE_SPECIAL: begin
          if (cmd_field == SCE_SF_IRQ_SET) begin
            ld.set_tgl = ~lq.set_tgl;
          end else if (cmd_field == SCE_SF_IRQ_CLR) begin
            ld.clr_tgl = ~lq.clr_tgl;
          end
        end
        default: begin
          ld.ptr = lq.ptr;
        end
      endcase
    end else if (LINK_WR_STB) begin
      // data byte, also an unmarked first byte, at the held address
      if (lq.ptr == SCE_ADDR_ENABLE) begin
        ld.en = sce_enable_t'(LINK_WR_DATA & SCE_ENABLE_WMASK);
      end else begin
        ld.wr_stb  = 1'b1;
        ld.wr_addr = lq.ptr;
        ld.wr_data = LINK_WR_DATA;
      end
      if (lq.mode == SCE_MODE_AUTOINC) begin
        ld.ptr = 5'(lq.ptr + 5'h01);
      end
    end else if (LINK_RD_STB) begin
      // read at the held address
      case (lq.ptr)
        SCE_ADDR_ENABLE: ld.rd_data = lq.en;
        SCE_ADDR_STATUS: begin
          ld.rd_data = 8'h00;
          ld.rd_data[SCE_STATUS_PINT_BIT] = lq.pint_s2;
        end
        default:         ld.rd_data = 8'h00;
      endcase
      if (lq.mode == SCE_MODE_AUTOINC) begin
        ld.ptr = 5'(lq.ptr + 5'h01);
      end
    end
  end

  // link side registers
  always_ff @(posedge LINK_CLK or negedge RESETN) begin
    if (!RESETN) begin
      lq         <= '0;
      lq.ptr     <= SCE_PTR_RST;
      lq.mode    <= SCE_MODE_REPEAT;
      lq.en      <= sce_enable_t'(SCE_ENABLE_RST);
    end else begin
      lq <= ld;
    end
  end

  // event edges from toggle synchronisers
  assign set_ev = cq.set_sync[1] ^ cq.set_sync[2];
  assign clr_ev = cq.clr_sync[1] ^ cq.clr_sync[2];

  // core side next state
  always_comb begin
    cd          = cq;
    cd.en_s1    = lq.en;
    cd.en_s2    = cq.en_s1;
    cd.set_sync = {cq.set_sync[1:0], lq.set_tgl};
    cd.clr_sync = {cq.clr_sync[1:0], lq.clr_tgl};
    // set beats clear in the same cycle
    cd.pend = (cq.pend && !clr_ev) || set_ev || PROX_IRQ_EVENT;
    if (!cd.pend) begin
      cd.sleep = 1'b0;
    end else if (PROX_CYCLE_END && cq.en_s2.sleep_after_irq) begin
      cd.sleep = 1'b1;
    end
    cd.int_n   = !(cd.pend && cq.en_s2.prox_irq_route_enable);
    cd.osc     = cq.en_s2.oscillator_power_on && !cd.sleep;
    cd.prox    = cd.osc && cq.en_s2.prox_measure_enable;
    cd.wait_en = cd.osc && cq.en_s2.wait_enable;
  end

  // core side registers
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cq       <= '0;
      cq.int_n <= 1'b1;
    end else begin
      cq <= cd;
    end
  end

  // outputs straight from flops
  assign LINK_RD_DATA  = lq.rd_data;
  assign REG_WR_STB    = lq.wr_stb;
  assign REG_WR_ADDR   = lq.wr_addr;
  assign REG_WR_DATA   = lq.wr_data;
  assign INT_N         = cq.int_n;
  assign OSC_ON        = cq.osc;
  assign PROX_MEAS_EN  = cq.prox;
  assign WAIT_TIMER_EN = cq.wait_en;
  assign SLEEP_STATE   = cq.sleep;

  // link side sequences
  sequence s_data_byte;
    LINK_WR_STB && !is_cmd;
  endsequence

  sequence s_auto_data;
    s_data_byte ##0 (lq.mode == SCE_MODE_AUTOINC);
  endsequence

  sequence s_repeat_data;
    s_data_byte ##0 (lq.mode == SCE_MODE_REPEAT);
  endsequence

  property p_auto_cmd;
    @(posedge LINK_CLK) disable iff (!RESETN)
      (is_cmd && cmd_type == SCE_TYPE_AUTO)
      |=> (lq.ptr == $past(cmd_field)) && (lq.mode == SCE_MODE_AUTOINC);
  endproperty
  a_auto_cmd: assert property (p_auto_cmd) else $error("pointer not loaded");

  property p_auto_step;
    @(posedge LINK_CLK) disable iff (!RESETN)
      s_auto_data |=> lq.ptr == 5'($past(lq.ptr) + 5'h01);
  endproperty
  a_auto_step: assert property (p_auto_step) else $error("pointer not advanced");

  property p_repeat_hold;
    @(posedge LINK_CLK) disable iff (!RESETN)
      s_repeat_data |=> $stable(lq.ptr);
  endproperty
  a_repeat_hold: assert property (p_repeat_hold) else $error("pointer moved");

  property p_rsvd_type;
    @(posedge LINK_CLK) disable iff (!RESETN)
      (is_cmd && cmd_type != SCE_TYPE_REPEAT && cmd_type != SCE_TYPE_AUTO)
      |=> $stable(lq.ptr) && $stable(lq.mode) && $stable(lq.en);
  endproperty
  a_rsvd_type: assert property (p_rsvd_type)
    else $error("pointer changed by non-address command");

  property p_enable_write;
    @(posedge LINK_CLK) disable iff (!RESETN)
      (s_data_byte ##0 (lq.ptr == SCE_ADDR_ENABLE))
      |=> lq.en == sce_enable_t'($past(LINK_WR_DATA) & SCE_ENABLE_WMASK);
  endproperty
  a_enable_write: assert property (p_enable_write)
    else $error("enable not written");

  // special function and address command sequences
  sequence s_special;
    is_cmd && (cmd_type == SCE_TYPE_SPECIAL);
  endsequence

  sequence s_repeat_cmd;
    is_cmd && (cmd_type == SCE_TYPE_REPEAT);
  endsequence

  property p_repeat_cmd;
    @(posedge LINK_CLK) disable iff (!RESETN)
      s_repeat_cmd |=> (lq.ptr == $past(cmd_field)) && (lq.mode == SCE_MODE_REPEAT);
  endproperty
  a_repeat_cmd: assert property (p_repeat_cmd)
    else $error("repeat pointer not loaded");

  property p_set_cmd;
    @(posedge LINK_CLK) disable iff (!RESETN)
      (s_special ##0 (cmd_field == SCE_SF_IRQ_SET)) |=> lq.set_tgl != $past(lq.set_tgl);
  endproperty
  a_set_cmd: assert property (p_set_cmd)
    else $error("force function not passed on");

  property p_clr_cmd;
    @(posedge LINK_CLK) disable iff (!RESETN)
      (s_special ##0 (cmd_field == SCE_SF_IRQ_CLR)) |=> lq.clr_tgl != $past(lq.clr_tgl);
  endproperty
  a_clr_cmd: assert property (p_clr_cmd)
    else $error("clear function not passed on");

  property p_other_sf;
    @(posedge LINK_CLK) disable iff (!RESETN)
      (s_special ##0 (cmd_field != SCE_SF_IRQ_SET) ##0 (cmd_field != SCE_SF_IRQ_CLR))
      |=> $stable(lq.set_tgl) && $stable(lq.clr_tgl);
  endproperty
  a_other_sf: assert property (p_other_sf)
    else $error("unknown function had an effect");

  property p_status_read;
    @(posedge LINK_CLK) disable iff (!RESETN)
      (LINK_RD_STB && !LINK_WR_STB && (lq.ptr == SCE_ADDR_STATUS))
      |=> LINK_RD_DATA[SCE_STATUS_PINT_BIT] == $past(lq.pint_s2);
  endproperty
  a_status_read: assert property (p_status_read)
    else $error("status does not show the interrupt");

  property p_data_write;
    @(posedge LINK_CLK) disable iff (!RESETN)
      (s_data_byte ##0 (lq.ptr != SCE_ADDR_ENABLE))
      |=> REG_WR_STB && (REG_WR_ADDR == $past(lq.ptr)) && (REG_WR_DATA == $past(LINK_WR_DATA));
  endproperty
  a_data_write: assert property (p_data_write)
    else $error("data byte not at held address");

  // link side reset values, checked one edge after reset is seen
  property p_link_reset;
    @(posedge LINK_CLK)
      !RESETN |=> (lq.ptr == SCE_PTR_RST) && (lq.mode == SCE_MODE_REPEAT)
                  && (lq.en == sce_enable_t'(SCE_ENABLE_RST)) && !REG_WR_STB;
  endproperty
  a_link_reset: assert property (p_link_reset)
    else $error("link side not at reset values");

  // core side properties
  property p_force;
    @(posedge CLK) disable iff (!RESETN)
      set_ev |=> cq.pend;
  endproperty
  a_force: assert property (p_force) else $error("forced interrupt not pending");

  property p_hold;
    @(posedge CLK) disable iff (!RESETN)
      (cq.pend && !clr_ev) |=> cq.pend;
  endproperty
  a_hold: assert property (p_hold) else $error("interrupt released without clear");

  property p_clear;
    @(posedge CLK) disable iff (!RESETN)
      (clr_ev && !set_ev && !PROX_IRQ_EVENT) |=> !cq.pend && !cq.sleep && INT_N;
  endproperty
  a_clear: assert property (p_clear) else $error("clear left state");

  property p_pin_masked;
    @(posedge CLK) disable iff (!RESETN)
      !cq.en_s2.prox_irq_route_enable |=> INT_N;
  endproperty
  a_pin_masked: assert property (p_pin_masked)
    else $error("pin driven while masked");

  property p_pin_shown;
    @(posedge CLK) disable iff (!RESETN)
      (cq.pend && !clr_ev && cq.en_s2.prox_irq_route_enable) |=> !INT_N;
  endproperty
  a_pin_shown: assert property (p_pin_shown) else $error("pin not driven");

  property p_sleep;
    @(posedge CLK) disable iff (!RESETN)
      (PROX_CYCLE_END && cq.en_s2.sleep_after_irq && cq.pend && !clr_ev)
      |=> SLEEP_STATE && !OSC_ON && !PROX_MEAS_EN;
  endproperty
  a_sleep: assert property (p_sleep) else $error("no sleep after interrupt");

  property p_osc_off;
    @(posedge CLK) disable iff (!RESETN)
      !cq.en_s2.oscillator_power_on |=> !OSC_ON && !WAIT_TIMER_EN;
  endproperty
  a_osc_off: assert property (p_osc_off) else $error("oscillator on while off");

  property p_prox_on;
    @(posedge CLK) disable iff (!RESETN)
      (cq.en_s2.oscillator_power_on && !SLEEP_STATE && !PROX_CYCLE_END)
      |=> OSC_ON && (PROX_MEAS_EN == $past(cq.en_s2.prox_measure_enable));
  endproperty
  a_prox_on: assert property (p_prox_on)
    else $error("proximity enable not followed");

  property p_wait_on;
    @(posedge CLK) disable iff (!RESETN)
      (cq.en_s2.oscillator_power_on && !SLEEP_STATE && !PROX_CYCLE_END)
      |=> WAIT_TIMER_EN == $past(cq.en_s2.wait_enable);
  endproperty
  a_wait_on: assert property (p_wait_on)
    else $error("wait enable not followed");

  property p_core_reset;
    @(posedge CLK)
      !RESETN |=> INT_N && !OSC_ON && !PROX_MEAS_EN && !WAIT_TIMER_EN && !SLEEP_STATE;
  endproperty
  a_core_reset: assert property (p_core_reset)
    else $error("core side not at reset values");

endmodule
`default_nettype wire

/* File: verif/sce_host_model.sv */
// host side byte model for the serial register link
`default_nettype none
module sce_host_model (
  input  wire logic       LINK_CLK, // link byte clock
  output var  logic       wr_stb,   // byte written
  output var  logic       wr_first, // first byte of a write
  output var  logic [7:0] wr_data,  // written byte
  output var  logic       rd_stb    // read request
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle bus at time zero
  initial begin
    wr_stb = 1'b0;
    wr_first = 1'b0;
    wr_data = 8'h00;
    rd_stb = 1'b0;
  end
  // one written byte; a transfer opens with its command byte
  task automatic wr(input logic f, input logic [7:0] d);
    @(posedge LINK_CLK);
    #1;
    wr_stb = 1'b1;
    wr_first = f;
    wr_data = d;
    @(posedge LINK_CLK);
    #1;
    wr_stb = 1'b0;
    wr_first = 1'b0;
    wr_data = ~d; // released bus, stale value hidden
  endtask
  // one read byte at the held pointer
  task automatic rd();
    @(posedge LINK_CLK);
    #1;
    rd_stb = 1'b1;
    @(posedge LINK_CLK);
    #1;
    rd_stb = 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: verif/sce_cmd_enable_bench.sv */
// self-checking bench for the command decoder and enable block
`default_nettype none
module sce_cmd_enable_bench
  import sce_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic lclk = 1'b0;
  logic resetn = 1'b0;
  logic ev = 1'b0;
  logic ce = 1'b0;
  wire logic ws, wf, rs;
  wire logic [7:0] wd;
  logic [7:0] rdat, wdat, v, rnd;
  logic [4:0] wadr;
  logic int_n, osc, prox, wten, slp, wstb;
  logic rd_q = 1'b0;
  logic [12:0] wq[$];
  logic [7:0] rq[$];
  integer seed = 32'hcacf6bdd;
  int num_errors = 0;
  int num_checks = 0;
  int cyc_n = 0;
  // clocks, link clock unrelated in phase
  initial forever #2.5 clk = ~clk;
  initial begin
    #3.1;
    forever #7.5 lclk = ~lclk;
  end
  sce_host_model i_host (.LINK_CLK(lclk), .wr_stb(ws), .wr_first(wf), .wr_data(wd), .rd_stb(rs));
  sce_cmd_enable i_dut (
    .CLK(clk), .RESETN(resetn), .LINK_CLK(lclk), .LINK_WR_STB(ws), .LINK_WR_FIRST(wf),
    .LINK_WR_DATA(wd), .LINK_RD_STB(rs), .LINK_RD_DATA(rdat), .REG_WR_STB(wstb),
    .REG_WR_ADDR(wadr), .REG_WR_DATA(wdat), .PROX_IRQ_EVENT(ev), .PROX_CYCLE_END(ce),
    .INT_N(int_n), .OSC_ON(osc), .PROX_MEAS_EN(prox), .WAIT_TIMER_EN(wten), .SLEEP_STATE(slp)
  );
  task automatic chk(input string n, input logic [12:0] s, input logic [12:0] e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic summarize();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic settle();
    repeat (12) @(posedge clk);
    #1;
  endtask
  task automatic cyc(input logic e, input logic c);
    @(posedge clk);
    #1;
    ev = e;
    ce = c;
    @(posedge clk);
    #1;
    ev = 1'b0;
    ce = 1'b0;
    settle();
  endtask
  task automatic en(input logic [7:0] e);
    i_host.wr(1'b1, 8'h80);
    i_host.wr(1'b0, e & 8'h6d);
    settle();
  endtask
  task automatic sf(input logic [7:0] c);
    i_host.wr(1'b1, c);
    settle();
  endtask
  task automatic rd(input logic [7:0] e);
    rq.push_back(e);
    i_host.rd();
  endtask
  task automatic pins(input logic [4:0] e);
    chk("pins", {int_n, slp, osc, prox, wten}, e);
  endtask
  // monitor takes the oldest note for every result seen
  always @(posedge lclk) begin
    if (rd_q === 1'b1) chk("read", rdat, rq.pop_front());
    rd_q <= rs;
    if (wstb === 1'b1) chk("wr", {wadr, wdat}, wq.pop_front());
  end
  // cycle ceiling
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      num_errors++;
      summarize();
    end
  end
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    #1;
    resetn = 1'b1;
    settle();
    pins(5'h10);
    rd(8'h00);
    repeat (3) begin
      v = 8'($random(seed)) & 8'h6d;
      rnd = 8'($random(seed));
      i_host.wr(1'b1, 8'ha0);
      i_host.wr(1'b0, v);
      wq.push_back({5'h01, rnd});
      i_host.wr(1'b0, rnd);
      settle();
      pins({2'b10, v[0], v[0] & v[2], v[0] & v[3]});
      i_host.wr(1'b1, 8'h80);
      rd(v);
    end
    en(8'h0d);
    pins(5'h17);
    for (int i = 0; i < 2; i++) begin
      v = 8'($random(seed));
      wq.push_back({5'h03, v});
      if (i == 0) i_host.wr(1'b1, 8'h83);
      i_host.wr(1'b0, v);
    end
    wq.push_back({5'h03, 8'h12});
    i_host.wr(1'b1, 8'h12);
    i_host.wr(1'b1, 8'hbf);
    wq.push_back({5'h1f, 8'h5a});
    i_host.wr(1'b0, 8'h5a);
    i_host.wr(1'b0, 8'h01);
    wq.push_back({5'h01, 8'h33});
    i_host.wr(1'b0, 8'h33);
    en(8'h21);
    sf(8'he4);
    pins(5'h04);
    sf(8'he6);
    sf(8'hc4);
    pins(5'h04);
    i_host.wr(1'b1, 8'h93);
    rd(8'h20);
    sf(8'he5);
    pins(5'h14);
    rd(8'h00);
    en(8'h01);
    sf(8'he4);
    pins(5'h14);
    i_host.wr(1'b1, 8'h93);
    rd(8'h20);
    sf(8'he5);
    en(8'h65);
    cyc(1'b0, 1'b1);
    pins(5'h16);
    cyc(1'b1, 1'b0);
    cyc(1'b0, 1'b1);
    pins(5'h08);
    sf(8'he5);
    pins(5'h16);
    // second reset in mid-run
    @(posedge clk);
    #1;
    resetn = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    resetn = 1'b1;
    settle();
    pins(5'h10);
    rd(8'h00);
    repeat (4) @(posedge lclk);
    chk("queues", 13'(wq.size() + rq.size()), 13'h0000);
    summarize();
  end
endmodule
`default_nettype wire
